// ===== common/mrt_pkg.sv
// shared constants and carriers for the refresh slot and talk interrupt block
package mrt_pkg;

    // refresh slot timing, in core steps
    localparam int unsigned REFRESH_PERIOD   = 255;
    localparam int unsigned REFRESH_PROC     = 20;
    localparam int unsigned REFRESH_CNT_W    = 8;

    // diagnostic entry sequence values
    localparam logic [7:0]  DIAG_A_ENTRY     = 8'h1a;
    localparam logic [15:0] SMR_ENTRY        = 16'h007f;
    localparam logic [3:0]  DIAG_B_ISOLATED  = 4'h4;
    localparam logic [3:0]  DIAG_B_DIAG      = 4'h0;
    localparam logic [3:0]  DIAG_B_NORMAL    = 4'h5;

    // field positions
    localparam int unsigned SMR_TALK_CLR_BIT = 1;
    localparam int unsigned DIAG_B_STEP_BIT  = 3;

    // reset values
    localparam logic [7:0]  REFRESH_CNT_RST  = 8'h00;
    localparam logic [15:0] SMR_RST          = 16'h0000;

    // diagnostic status flags seen by the host
    typedef struct packed {
        logic refresh_seen;
        logic refresh_sync;
        logic refresh_busy;
        logic diag_mode;
        logic isolated;
    } mrt_diag_stat_t;

    // entry sequence tracker
    typedef enum logic [1:0] {
        MRT_SEQ_IDLE = 2'b00,
        MRT_SEQ_GOT_A = 2'b01,
        MRT_SEQ_GOT_S = 2'b10
    } mrt_seq_t;

endpackage

// ===== rtl/mrt_refresh_talk.sv
// refresh counter, refresh slot and display talk interrupt
// Notes on behaviour
// - refresh slots start every 255 core steps
// - counter readback is valid only while the slot is at its sync point
// - a detected refresh slot completes within 20 core steps
// - each bit of the counter low byte is writable and reads back unchanged
// - talk interrupt raised when data ready pulses high then returns low
// - writing one to bit 1 of the status and mode register clears it
// - diagnostic entry: 1a to port a, 007f to mode register, 4 to port b
// - refresh occurrence flagged in diagnostic status; slot recurs unasked
`timescale 1ns/1ps
module mrt_refresh_talk (
    // clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   sys_rst_i,
    // host write strobes, same clock domain
    input  wire logic                   diag_a_we_i,
    input  wire logic [7:0]             diag_a_wdata_i,
    input  wire logic                   diag_b_we_i,
    input  wire logic [3:0]             diag_b_wdata_i,
    input  wire logic                   status_mode_register_we_i,
    input  wire logic [15:0]            status_mode_register_wdata_i,
    input  wire logic                   refresh_cnt_we_i,
    input  wire logic [7:0]             refresh_cnt_wdata_i,
    // display processor handshake pin
    input  wire logic                   display_data_ready_i,
    // readback and events
    output logic [7:0]                  diag_readback_o,
    output logic                        diag_readback_valid_o,
    output mrt_pkg::mrt_diag_stat_t     diag_stat_o,
    output logic                        refresh_grant_o,
    output logic                        talk_irq_o
);
    import mrt_pkg::*;

    // core state; all outputs further down are flops, so none can glitch
    logic [7:0]  refresh_cnt_r;
    logic [7:0]  slot_cnt_r;
    logic [4:0]  proc_cnt_r;
    logic        busy_r;
    logic        seen_r;
    logic        diag_r;
    logic        iso_r;
    logic        step_last_r;
    logic        rdy_meta_r;
    logic        rdy_sync_r;
    logic        rdy_high_r;
    logic        talk_r;
    logic        adv;
    logic        sync_pt;
    logic        talk_clr;
    logic        talk_set;
    mrt_seq_t    seq_r;

    ////////////////////////////////////////////////////////////////////////
    // step enable: free running normally, one edge of the step bit in diag
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            step_last_r <= 1'b0;
        end else if (diag_b_we_i) begin
            step_last_r <= diag_b_wdata_i[DIAG_B_STEP_BIT];
        end
    end

    // the step bit must fall again before another pulse counts
    // a rising step bit is exactly one core step
    assign adv = diag_r ? (diag_b_we_i && diag_b_wdata_i[DIAG_B_STEP_BIT]
                           && !step_last_r) : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // diagnostic entry sequence; order matters, any stray write to port a, port b or the mode register restarts it
    // the normal value on port b outside the sequence leaves diagnostics
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            seq_r  <= MRT_SEQ_IDLE;
            diag_r <= 1'b0;
            iso_r  <= 1'b0;
        end else begin
            if (diag_a_we_i) begin
                seq_r <= (diag_a_wdata_i == DIAG_A_ENTRY) ? MRT_SEQ_GOT_A
                                                          : MRT_SEQ_IDLE;
            end else if (status_mode_register_we_i) begin
                seq_r <= (seq_r == MRT_SEQ_GOT_A &&
                          status_mode_register_wdata_i == SMR_ENTRY)
                         ? MRT_SEQ_GOT_S : MRT_SEQ_IDLE;
            end else if (diag_b_we_i) begin
                seq_r <= MRT_SEQ_IDLE;
                if (seq_r == MRT_SEQ_GOT_S) begin
                    // enter plain or isolated diagnostic mode
                    diag_r <= (diag_b_wdata_i == DIAG_B_DIAG) ||
                              (diag_b_wdata_i == DIAG_B_ISOLATED);
                    iso_r  <= (diag_b_wdata_i == DIAG_B_ISOLATED);
                end else if (diag_b_wdata_i == DIAG_B_NORMAL) begin
                    diag_r <= 1'b0;
                    iso_r  <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refresh slot timer; recurs with no request at all
    // counts 0..254 and wraps, so slot starts lie 255 steps apart
    assign sync_pt = (slot_cnt_r == 8'(REFRESH_PERIOD - 1));

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            slot_cnt_r <= 8'h00;
        end else if (adv) begin
            slot_cnt_r <= sync_pt ? 8'h00 : slot_cnt_r + 8'h01;
        end
    end

    // processing window after each slot start
    // 20 steps of work; a new slot start would restart the count
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            busy_r     <= 1'b0;
            proc_cnt_r <= 5'h00;
        end else if (adv) begin
            if (sync_pt) begin
                busy_r     <= 1'b1;
                proc_cnt_r <= 5'h00;
            end else if (busy_r) begin
                proc_cnt_r <= proc_cnt_r + 5'h01;
                if (proc_cnt_r == 5'(REFRESH_PROC - 1)) begin
                    busy_r <= 1'b0; // done within 20 steps
                end
            end
        end
    end

    // sticky occurrence flag, cleared by leaving diagnostics
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            seen_r <= 1'b0;
        end else if (adv && sync_pt) begin
            seen_r <= 1'b1;
        end else if (!diag_r) begin
            seen_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refresh row counter; host write wins over the advance on a slot
    // the price: a write in the wrap cycle drops that one advance
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            refresh_cnt_r <= REFRESH_CNT_RST;
        end else if (refresh_cnt_we_i) begin
            refresh_cnt_r <= refresh_cnt_wdata_i;
        end else if (adv && sync_pt && !diag_r) begin
            // frozen in diagnostics so written patterns read back intact
            refresh_cnt_r <= refresh_cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback port and grant pulse
    // the count is gated to zero away from sync so no stale value shows
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            diag_readback_o       <= 8'h00;
            diag_readback_valid_o <= 1'b0;
            refresh_grant_o       <= 1'b0;
            diag_stat_o           <= '0;
        end else begin
            diag_readback_valid_o <= sync_pt;
            diag_readback_o       <= sync_pt ? refresh_cnt_r : 8'h00;
            refresh_grant_o       <= adv && sync_pt;
            diag_stat_o           <= '{refresh_seen: seen_r,
                                       refresh_sync: sync_pt,
                                       refresh_busy: busy_r,
                                       diag_mode:    diag_r,
                                       isolated:     iso_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data ready pin synchroniser, first stage read only by the second
    // the pin runs on the display side's timing, hence two stages
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdy_meta_r <= 1'b0;
            rdy_sync_r <= 1'b0;
            rdy_high_r <= 1'b0;
        end else begin
            rdy_meta_r <= display_data_ready_i;
            rdy_sync_r <= rdy_meta_r;
            rdy_high_r <= rdy_sync_r;
        end
    end

    // the falling edge ends the high pulse
    assign talk_set = rdy_high_r && !rdy_sync_r;
    assign talk_clr = status_mode_register_we_i &&
                      status_mode_register_wdata_i[SMR_TALK_CLR_BIT];

    // sticky request; a new pulse beats a clear in the same cycle
    // a clear with nothing pending leaves the flag low
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            talk_r <= 1'b0;
        end else if (talk_set) begin
            talk_r <= 1'b1;
        end else if (talk_clr) begin
            talk_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin straight from a flop; costs one cycle of latency
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            talk_irq_o <= 1'b0;
        end else begin
            talk_irq_o <= talk_r;
        end
    end

endmodule // mrt_refresh_talk

// ===== verification/mrt_refresh_talk_chk.sv
// port assertions for the refresh slot and talk interrupt block
`timescale 1ns/1ps
module mrt_refresh_talk_chk
    import mrt_pkg::*;
(
    // clock, reset and host side
    input wire logic           ref_clk_i, sys_rst_i,
    input wire logic           diag_a_we_i, diag_b_we_i,
    input wire logic           status_mode_register_we_i,
    input wire logic [7:0]     diag_a_wdata_i,
    input wire logic [3:0]     diag_b_wdata_i,
    input wire logic [15:0]    status_mode_register_wdata_i,
    input wire logic           display_data_ready_i,
    // observed outputs
    input wire logic [7:0]     diag_readback_o,
    input wire logic           diag_readback_valid_o, refresh_grant_o,
    input wire logic           talk_irq_o,
    input wire mrt_diag_stat_t diag_stat_o
);
    logic [8:0] gap_r;
    logic       gap_ok_r;
    wire        dg = diag_stat_o.diag_mode;
    wire        clr = status_mode_register_we_i
                      && status_mode_register_wdata_i[SMR_TALK_CLR_BIT];
    // cycles since last grant; a diag spell voids the measure
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || refresh_grant_o) gap_r <= 9'h000;
        else gap_r <= gap_r + 9'h001;
    end
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || dg) gap_ok_r <= 1'b0;
        else if (refresh_grant_o) gap_ok_r <= 1'b1;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_period; refresh_grant_o && gap_ok_r |-> gap_r == 9'h0fe;
    endproperty
    a_period: assert property (p_period) else $error("bad spacing");
    property p_recur; gap_ok_r && !dg |-> gap_r < 9'h0ff; endproperty
    a_recur: assert property (p_recur) else $error("slot missing");
    property p_valid; !dg |-> diag_readback_valid_o == refresh_grant_o;
    endproperty
    a_valid: assert property (p_valid) else $error("valid off");
    property p_zero; !diag_readback_valid_o |-> diag_readback_o == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("readback leak");
    property p_busy;
        refresh_grant_o && !dg |-> ##21 (!diag_stat_o.refresh_busy || dg);
    endproperty
    a_busy: assert property (p_busy) else $error("busy too long");
    property p_set; $fell(display_data_ready_i) |-> ##[4:5] talk_irq_o;
    endproperty
    a_set: assert property (p_set) else $error("no talk irq");
    property p_clr; clr && talk_irq_o |-> ##2 !talk_irq_o; endproperty
    a_clr: assert property (p_clr) else $error("irq not cleared");
    // a clear needs two cycles to reach the pin, so skip its shadow
    property p_hold;
        talk_irq_o && !clr && !$past(clr) |=> talk_irq_o;
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_entry;
        diag_a_we_i && diag_a_wdata_i == DIAG_A_ENTRY ##1
        status_mode_register_we_i
        && status_mode_register_wdata_i == SMR_ENTRY ##1
        diag_b_we_i && diag_b_wdata_i == DIAG_B_ISOLATED
        // mode flag sits two flops behind the port b write
        |-> ##2 dg && diag_stat_o.isolated;
    endproperty
    a_entry: assert property (p_entry) else $error("no entry");
    property p_step;
        refresh_grant_o && dg |-> $past(diag_b_we_i) || $past(diag_b_we_i, 2);
    endproperty
    a_step: assert property (p_step) else $error("free run");
endmodule // mrt_refresh_talk_chk
bind mrt_refresh_talk mrt_refresh_talk_chk u_mrt_refresh_talk_chk (.*);

// ===== verification/mrt_display_model.sv
// display processor side: pulses the data ready handshake pin
`timescale 1ns/1ps
module mrt_display_model (
    // clock and command from the bench
    input  wire logic       ref_clk_i,
    input  wire logic       fire_i,
    input  wire logic [3:0] width_i,
    // handshake pin toward the block
    output logic            display_data_ready_o
);
    logic [3:0] left_r = 4'h0;
    // high for width cycles then back low; idle level is low
    always @(posedge ref_clk_i) begin
        if (fire_i) left_r <= width_i;
        else if (left_r != 4'h0) left_r <= left_r - 4'h1;
    end
    assign display_data_ready_o = (left_r != 4'h0);
endmodule // mrt_display_model

// ===== verification/mrt_refresh_talk_bench.sv
// self-checking bench for the refresh slot and talk interrupt block
`timescale 1ns/1ps
module mrt_refresh_talk_bench;
    import mrt_pkg::*;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, fire = 1'b0;
    logic diag_a_we_i = 1'b0, diag_b_we_i = 1'b0, refresh_cnt_we_i = 1'b0;
    logic status_mode_register_we_i = 1'b0;
    logic [7:0] diag_a_wdata_i = '0, refresh_cnt_wdata_i = '0;
    logic [3:0] diag_b_wdata_i = '0, width = 4'h1;
    logic [15:0] status_mode_register_wdata_i = '0;
    logic display_data_ready_i, diag_readback_valid_o;
    logic refresh_grant_o, talk_irq_o;
    logic [7:0] diag_readback_o;
    mrt_diag_stat_t diag_stat_o;
    int miscompares = 0, cmp_count = 0, n;
    logic [31:0] seed = 32'he1db977b;
    mrt_refresh_talk u_mrt_refresh_talk (.*);
    mrt_display_model u_mrt_display_model (.ref_clk_i, .fire_i(fire),
        .width_i(width), .display_data_ready_o(display_data_ready_i));
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic clk(int k);
        repeat (k) @(posedge ref_clk_i);
    endtask
    // one host write per edge; s=4 leaves every strobe low
    task automatic wr(int s, logic [15:0] d);
        @(posedge ref_clk_i);
        diag_a_we_i <= (s == 0);
        diag_b_we_i <= (s == 1);
        status_mode_register_we_i <= (s == 2);
        refresh_cnt_we_i <= (s == 3);
        diag_a_wdata_i <= d[7:0];
        refresh_cnt_wdata_i <= d[7:0];
        diag_b_wdata_i <= d[3:0];
        status_mode_register_wdata_i <= d;
    endtask
    // one diagnostic step: step bit high then low
    task automatic step();
        wr(1, 16'h0008);
        wr(1, 16'h0000);
        wr(4, 16'h0000);
        clk(2);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: a hang counts against the run
    initial begin
        clk(60000);
        miscompares++;
        test_done();
    end
    initial begin
        clk(8);
        sys_rst_i <= 1'b0;
        clk(2);
        chk(talk_irq_o, 0);
        // free-running slot: spacing, readback strobe, busy window
        n = 0;
        while (!refresh_grant_o && n < 300) begin clk(1); n++; end
        n = 0;
        do begin
            clk(1);
            n++;
            chk(diag_readback_valid_o, refresh_grant_o);
        end while (!refresh_grant_o && n < 300);
        chk(16'(n), 255);
        clk(2);
        chk(diag_stat_o.refresh_busy, 1);
        clk(19);
        chk(diag_stat_o.refresh_busy, 0);
        $display("slot test done");
        // talk interrupt: random pulse widths, clear with random mode data
        repeat (4) begin
            width <= 4'(rnd() % 8 + 1);
            fire <= 1'b1;
            clk(1);
            fire <= 1'b0;
            clk(16 + int'(rnd() % 4));
            chk(talk_irq_o, 1);
            wr(2, 16'(rnd()) | 16'h0002);
            wr(4, 16'h0000);
            clk(3);
            chk(talk_irq_o, 0);
        end
        $display("talk test done");
        // broken entry sequence must leave normal mode in force
        wr(0, DIAG_A_ENTRY);
        wr(2, 16'(rnd()) | 16'h0100);
        wr(1, DIAG_B_ISOLATED);
        wr(4, 16'h0000);
        clk(2);
        chk(diag_stat_o.diag_mode, 0);
        // isolated entry, then back to normal
        wr(0, DIAG_A_ENTRY); wr(2, SMR_ENTRY); wr(1, DIAG_B_ISOLATED);
        wr(4, 16'h0000);
        clk(2);
        chk({diag_stat_o.diag_mode, diag_stat_o.isolated}, 2'b11);
        wr(1, DIAG_B_NORMAL); wr(2, SMR_ENTRY); wr(4, 16'h0000);
        // stepped diag mode: find a slot, then walking ones
        wr(0, DIAG_A_ENTRY); wr(2, SMR_ENTRY); wr(1, DIAG_B_DIAG);
        wr(4, 16'h0000);
        n = 0;
        do begin step(); n++; end while (!diag_stat_o.refresh_seen && n < 600);
        chk(diag_stat_o.refresh_seen, 1);
        for (int i = 0; i < 8; i++) begin
            wr(3, 16'h0001 << i);
            n = 0;
            do begin step(); n++; end
            while (!diag_readback_valid_o && n < 300);
            chk(diag_readback_o, 8'h01 << i);
            chk(diag_stat_o.refresh_sync, 1);
            if (i > 0) chk(16'(n), 255);
        end
        wr(1, DIAG_B_NORMAL); wr(2, SMR_ENTRY); wr(4, 16'h0000);
        $display("diag test done");
        test_done();
    end
endmodule // mrt_refresh_talk_bench
